/* fmc_pkg.sv */
// Constants shared by the frequency measurement and cut-out block
package fmc_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam logic [13:0] MIN_RESP_MS_LO = 14'h0005;
  localparam logic [13:0] MIN_RESP_MS_HI = 14'h2710;
  localparam logic [31:0] FS_HZ_DEF = 32'h0000_2710;
  localparam int unsigned MAX_RESP_PERIODS = 1024;
  localparam logic [31:0] MAX_RESP_DEF = 32'(64'(MAX_RESP_PERIODS) * CLK_HZ / FS_HZ_DEF);
  localparam logic [63:0] MHZ_PER_HZ = 64'h0000_0000_0000_03e8;
  // Register byte offsets
  localparam logic [7:0] A_MIN_RESP = 8'h00;
  localparam logic [7:0] A_MAX_RESP = 8'h04;
  localparam logic [7:0] A_FS_HZ = 8'h08;
  localparam logic [7:0] A_CAL_MIN = 8'h0c;
  localparam logic [7:0] A_CAL_FS = 8'h10;
  localparam logic [7:0] A_FREQ = 8'h14;
  localparam logic [7:0] A_OUT_VAL = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1c;
  localparam logic [7:0] A_MASK = 8'h20;
  localparam logic [7:0] A_FLAGS = 8'h24;
  // Reset values of calibration endpoints
  localparam logic [15:0] CAL_MIN_DEF = 16'h0000;
  localparam logic [15:0] CAL_FS_DEF = 16'hffff;
  // Status bit positions
  localparam int ST_UPDATE = 0;
  localparam int ST_CUTOUT = 1;
  localparam int ST_OVER = 2;
  localparam int ST_CALREJ = 3;
  localparam int ST_W = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {S_IDLE, S_DIV_FREQ, S_DIV_SCALE} fmc_state_e;
endpackage : fmc_pkg

/* fmc_sync.sv */
// Two-stage synchroniser with falling edge detection for the pulse input
`timescale 1ns/100ps
module fmc_sync (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pin,
  output logic o_level,
  output logic o_fall
);
  logic meta;
  logic sync;
  logic prev;

  // First stage is read only by the second
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end
    else
    begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
    end
  end

  assign o_level = sync;
  assign o_fall = prev & ~sync;
endmodule : fmc_sync

/* fmc_div.sv */
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module fmc_div (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic [63:0] i_num,
  input wire logic [63:0] i_den,
  output logic o_done,
  output logic [63:0] o_quot
);
  logic [63:0] rem;
  logic [63:0] num;
  logic [63:0] den;
  logic [6:0] cnt;
  logic busy;
  logic [64:0] trial;

  assign trial = {rem, num[63]} - {1'b0, den};

  // Restart on every start, even while busy
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rem <= 64'h0;
      num <= 64'h0;
      den <= 64'h0;
      cnt <= 7'h0;
      busy <= 1'b0;
      o_done <= 1'b0;
      o_quot <= 64'h0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        rem <= 64'h0;
        num <= i_num;
        den <= i_den;
        cnt <= 7'h40;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (!trial[64])
        begin
          rem <= trial[63:0];
        end
        else
        begin
          rem <= {rem[62:0], num[63]};
        end
        num <= {num[62:0], ~trial[64]};
        cnt <= cnt - 7'h1;
        if (cnt == 7'h1)
        begin
          busy <= 1'b0;
          o_done <= 1'b1;
          o_quot <= {num[62:0], ~trial[64]};
        end
      end
    end
  end
endmodule : fmc_div

/* fmc_core.sv */
// Frequency measurement core with low-frequency cut-out and AXI4-Lite registers
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module fmc_core #(
  parameter int unsigned P_CYC_PER_MS = fmc_pkg::CYC_PER_MS,
  parameter logic [31:0] P_MAX_RESP_DEF = fmc_pkg::MAX_RESP_DEF
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_pulse,
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [15:0] o_out_value,
  output logic o_in_led,
  output logic o_out_led,
  output logic o_irq
);
  logic in_level;
  logic fall;
  logic [13:0] min_ms;
  logic [31:0] max_cyc;
  logic [31:0] fs_hz;
  logic [15:0] cal_min;
  logic [15:0] cal_fs;
  logic [31:0] freq_mhz;
  localparam int ST_W_C = fmc_pkg::ST_W;
  logic [ST_W_C-1:0] status;
  logic [ST_W_C-1:0] mask;
  logic [ST_W_C-1:0] st_set;
  logic [ST_W_C-1:0] st_clr;
  logic st_over;
  logic started;
  logic [31:0] win_cnt;
  logic [31:0] idle_cnt;
  logic [23:0] edges;
  logic [31:0] min_cyc;
  logic close;
  logic timeout;
  logic cutout;
  logic overrange;
  fmc_pkg::fmc_state_e state;
  logic div_start;
  logic [63:0] div_num;
  logic [63:0] div_den;
  logic div_done;
  logic [63:0] div_q;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go;
  logic [31:0] wmask;
  logic cal_rej;

  fmc_sync u_sync (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_pin(i_pulse),
    .o_level(in_level),
    .o_fall(fall)
  );

  fmc_div u_div (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_start(div_start),
    .i_num(div_num),
    .i_den(div_den),
    .o_done(div_done),
    .o_quot(div_q)
  );

  // Window and timeout conditions
  assign min_cyc = 32'(min_ms * P_CYC_PER_MS);
  assign close = started && fall && (win_cnt >= min_cyc);
  assign timeout = started && !fall && (idle_cnt >= max_cyc);

  // Edge counting and window timing
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      started <= 1'b0;
      win_cnt <= 32'h0;
      idle_cnt <= 32'h0;
      edges <= 24'h0;
    end
    else if (fall)
    begin
      started <= 1'b1;
      idle_cnt <= 32'h0;
      win_cnt <= close || !started ? 32'h0 : win_cnt + 32'h1;
      edges <= close || !started ? 24'h0 : edges + 24'h1;
    end
    else
    begin
      if (timeout)
      begin
        started <= 1'b0;
      end
      // Saturate so a dead input cannot wrap the counters
      win_cnt <= (win_cnt == 32'hffff_ffff) ? win_cnt : win_cnt + 32'h1;
      idle_cnt <= (idle_cnt == 32'hffff_ffff) ? idle_cnt : idle_cnt + 32'h1;
    end
  end

  // Division and output sequencing
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state <= fmc_pkg::S_IDLE;
      div_start <= 1'b0;
      div_num <= 64'h0;
      div_den <= 64'h1;
      freq_mhz <= 32'h0;
      cutout <= 1'b0;
      overrange <= 1'b0;
      o_out_value <= fmc_pkg::CAL_MIN_DEF;
    end
    else
    begin
      div_start <= 1'b0;
      if (timeout)
      begin
        cutout <= 1'b1;
        overrange <= 1'b0;
        freq_mhz <= 32'h0;
        o_out_value <= cal_min;
        state <= fmc_pkg::S_IDLE;
      end
      else
      begin
        case (state)
          fmc_pkg::S_IDLE:
          begin
            if (close)
            begin
              // intervals times rate over elapsed cycles
              div_num <= 64'(edges + 24'h1) * 64'(P_CYC_PER_MS) * fmc_pkg::MHZ_PER_HZ * fmc_pkg::MHZ_PER_HZ;
              div_den <= 64'(win_cnt) + 64'h1;
              div_start <= 1'b1;
              state <= fmc_pkg::S_DIV_FREQ;
            end
          end
          fmc_pkg::S_DIV_FREQ:
          begin
            if (div_done)
            begin
              freq_mhz <= 32'(div_q);
              cutout <= 1'b0;
              if (div_q >= 64'(fs_hz) * fmc_pkg::MHZ_PER_HZ)
              begin
                overrange <= 1'b1;
                o_out_value <= cal_fs;
                state <= fmc_pkg::S_IDLE;
              end
              else
              begin
                overrange <= 1'b0;
                div_num <= div_q * 64'(cal_fs - cal_min);
                div_den <= 64'(fs_hz) * fmc_pkg::MHZ_PER_HZ;
                div_start <= 1'b1;
                state <= fmc_pkg::S_DIV_SCALE;
              end
            end
          end
          fmc_pkg::S_DIV_SCALE:
          begin
            if (div_done)
            begin
              o_out_value <= cal_min + div_q[15:0];
              state <= fmc_pkg::S_IDLE;
            end
          end
          default:
          begin
            state <= fmc_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // Lamps; input lamp tracks the synchronised level
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_in_led <= 1'b0;
      o_out_led <= 1'b0;
    end
    else
    begin
      o_in_led <= in_level;
      o_out_led <= cutout || timeout || overrange;
    end
  end

  // Write channel capture, either order
  assign wr_go = aw_got && w_got && !o_bvalid;
  assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= fmc_pkg::RESP_OKAY;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_got <= 1'b1;
        aw_addr <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_got <= 1'b1;
        w_data <= i_wdata;
        w_strb <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (aw_addr > fmc_pkg::A_FLAGS || aw_addr[1:0] != 2'h0 || cal_rej) ?
                   fmc_pkg::RESP_SLVERR : fmc_pkg::RESP_OKAY;
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  always_comb
  begin
    logic [31:0] nv;
    nv = (w_data & wmask) | ({16'h0, cal_min} & ~wmask);
    cal_rej = 1'b0;
    if (aw_addr == fmc_pkg::A_CAL_MIN)
    begin
      cal_rej = nv[15:0] >= cal_fs;
    end
    else if (aw_addr == fmc_pkg::A_CAL_FS)
    begin
      nv = (w_data & wmask) | ({16'h0, cal_fs} & ~wmask);
      cal_rej = nv[15:0] <= cal_min;
    end
  end

  // Software-written configuration
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      min_ms <= fmc_pkg::MIN_RESP_MS_LO;
      max_cyc <= P_MAX_RESP_DEF;
      fs_hz <= fmc_pkg::FS_HZ_DEF;
      cal_min <= fmc_pkg::CAL_MIN_DEF;
      cal_fs <= fmc_pkg::CAL_FS_DEF;
      mask <= '0;
    end
    else if (wr_go && !cal_rej)
    begin
      case (aw_addr)
        fmc_pkg::A_MIN_RESP:
        begin
          if (w_data[31:0] < 32'(fmc_pkg::MIN_RESP_MS_LO))
            min_ms <= fmc_pkg::MIN_RESP_MS_LO;
          else if (w_data[31:0] > 32'(fmc_pkg::MIN_RESP_MS_HI))
            min_ms <= fmc_pkg::MIN_RESP_MS_HI;
          else
            min_ms <= w_data[13:0];
        end
        fmc_pkg::A_MAX_RESP: max_cyc <= (w_data & wmask) | (max_cyc & ~wmask);
        // Zero full scale would force every window over range
        fmc_pkg::A_FS_HZ: fs_hz <= (w_data == 32'h0) ? fs_hz : w_data;
        fmc_pkg::A_CAL_MIN: cal_min <= 16'((w_data & wmask) | ({16'h0, cal_min} & ~wmask));
        fmc_pkg::A_CAL_FS: cal_fs <= 16'((w_data & wmask) | ({16'h0, cal_fs} & ~wmask));
        fmc_pkg::A_MASK: mask <= w_data[ST_W_C-1:0];
        default: mask <= mask;
      endcase
    end
  end

  // Sticky events; a set in the clearing cycle survives
  // A clamped window is an update as well
  assign st_over = state == fmc_pkg::S_DIV_FREQ && div_done && !timeout &&
                   div_q >= 64'(fs_hz) * fmc_pkg::MHZ_PER_HZ;
  assign st_set = {wr_go && cal_rej, st_over, timeout && !cutout,
                   st_over || (state == fmc_pkg::S_DIV_SCALE && div_done && !timeout)};
  assign st_clr = (wr_go && aw_addr == fmc_pkg::A_STATUS) ? w_data[ST_W_C-1:0] : '0;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      status <= '0;
      o_irq <= 1'b0;
    end
    else
    begin
      status <= (status & ~st_clr) | st_set;
      o_irq <= |((status & ~st_clr | st_set) & mask);
    end
  end

  // Read channel, one read outstanding
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= fmc_pkg::RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= fmc_pkg::RESP_OKAY;
      case (i_araddr)
        fmc_pkg::A_MIN_RESP: o_rdata <= {18'h0, min_ms};
        fmc_pkg::A_MAX_RESP: o_rdata <= max_cyc;
        fmc_pkg::A_FS_HZ: o_rdata <= fs_hz;
        fmc_pkg::A_CAL_MIN: o_rdata <= {16'h0, cal_min};
        fmc_pkg::A_CAL_FS: o_rdata <= {16'h0, cal_fs};
        fmc_pkg::A_FREQ: o_rdata <= freq_mhz;
        fmc_pkg::A_OUT_VAL: o_rdata <= {16'h0, o_out_value};
        fmc_pkg::A_STATUS: o_rdata <= {28'h0, status};
        fmc_pkg::A_MASK: o_rdata <= {28'h0, mask};
        fmc_pkg::A_FLAGS: o_rdata <= {30'h0, overrange, cutout};
        default:
        begin
          o_rdata <= 32'h0;
          o_rresp <= fmc_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Checks
  sequence s_close_launch;
    close && state == fmc_pkg::S_IDLE && !timeout ##1 div_start && state == fmc_pkg::S_DIV_FREQ;
  endsequence
  property p_close_launch;
    @(posedge i_clk) disable iff (!i_reset_n) close && state == fmc_pkg::S_IDLE && !timeout |-> s_close_launch;
  endproperty
  a_close_launch: assert property (p_close_launch) else $error("window close did not start divide");
  property p_min_window;
    @(posedge i_clk) disable iff (!i_reset_n) div_start && state == fmc_pkg::S_DIV_FREQ |->
      $past(fall) && $past(win_cnt) >= $past(min_cyc);
  endproperty
  a_min_window: assert property (p_min_window) else $error("window closed early");
  property p_min_range;
    @(posedge i_clk) disable iff (!i_reset_n) min_ms >= fmc_pkg::MIN_RESP_MS_LO && min_ms <= fmc_pkg::MIN_RESP_MS_HI;
  endproperty
  a_min_range: assert property (p_min_range) else $error("minimum response out of range");
  property p_cutout;
    @(posedge i_clk) disable iff (!i_reset_n) started && !fall && idle_cnt >= max_cyc |=> cutout && o_out_value == cal_min;
  endproperty
  a_cutout: assert property (p_cutout) else $error("cut-out not applied");
  property p_out_led;
    @(posedge i_clk) disable iff (!i_reset_n) cutout |=> o_out_led;
  endproperty
  a_out_led: assert property (p_out_led) else $error("output lamp dark in cut-out");
  property p_in_led;
    @(posedge i_clk) disable iff (!i_reset_n) ##1 o_in_led == $past(in_level);
  endproperty
  a_in_led: assert property (p_in_led) else $error("input lamp not following input");
  property p_cal_order;
    @(posedge i_clk) disable iff (!i_reset_n) cal_min < cal_fs;
  endproperty
  a_cal_order: assert property (p_cal_order) else $error("calibration endpoints out of order");
  property p_over;
    @(posedge i_clk) disable iff (!i_reset_n) $rose(overrange) |-> o_out_value == cal_fs ##1 o_out_led;
  endproperty
  a_over: assert property (p_over) else $error("over-range not clamped");
endmodule : fmc_core

/* fmc_pulse_gen.sv */
// Pulse source model standing in for the sensor on the input
`timescale 1ns/100ps
module fmc_pulse_gen (
  input wire logic i_clk,
  input wire logic i_run,
  input wire logic [15:0] i_period,
  input wire logic i_idle_level,
  output logic o_pulse
);
  logic [15:0] cnt;
  // High for the first half period, low for the rest; one fall per period
  // A stopped sensor leaves the line at its pull level, never a stale edge
  always_ff @(posedge i_clk)
  begin
    if (!i_run)
    begin
      cnt <= 16'h0000;
      o_pulse <= i_idle_level;
    end
    else
    begin
      cnt <= (cnt >= i_period - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
      o_pulse <= (cnt < (i_period >> 1));
    end
  end
endmodule : fmc_pulse_gen

/* tb_fmc_core.sv */
// Self-checking bench for the frequency measurement and cut-out core
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module tb_fmc_core;
  // 1024 periods of the 10 kHz default at the scaled 100 kHz rate
  localparam logic [31:0] MAXR = 32'h0000_2800;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic run = 1'b0;
  logic idle_lvl = 1'b1;
  logic [15:0] period = 16'h0064;
  logic pulse;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, in_led, out_led, irq;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata, rd;
  logic [15:0] out_value;
  int n_fail = 0;
  int n_tests = 0;
  int n;
  logic [7:0] ra [6] = '{fmc_pkg::A_MIN_RESP, fmc_pkg::A_MAX_RESP, fmc_pkg::A_FS_HZ,
                         fmc_pkg::A_CAL_MIN, fmc_pkg::A_CAL_FS, fmc_pkg::A_STATUS};
  logic [31:0] rv [6] = '{32'h0000_0005, MAXR, 32'h0000_2710, 32'h0000_0000, 32'h0000_ffff, 32'h0000_0000};

  fmc_core #(.P_CYC_PER_MS(100), .P_MAX_RESP_DEF(MAXR)) u_fmc_core (
    .i_clk(clk), .i_reset_n(reset_n), .i_pulse(pulse),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
    .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_out_value(out_value), .o_in_led(in_led), .o_out_led(out_led), .o_irq(irq)
  );
  fmc_pulse_gen u_fmc_pulse_gen (
    .i_clk(clk), .i_run(run), .i_period(period), .i_idle_level(idle_lvl), .o_pulse(pulse)
  );

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    r = 2'h3;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && k < 100)
    begin
      @(posedge clk);
      k++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        r = bresp;
        done = 1'b1;
      end
    end
    bready <= 1'b0;
    `CHK(done, 1'b1)
  endtask : wr

  // Read: rready held up until the data is sampled
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    logic done;
    k = 0;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && k < 100)
    begin
      @(posedge clk);
      k++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    rready <= 1'b0;
    `CHK(done, 1'b1)
  endtask : rdr

  // Clear the update flag, then poll until a fresh window completes
  task automatic wait_upd();
    logic [31:0] s;
    logic [1:0] r;
    int k;
    s = 32'h0000_0000;
    k = 0;
    wr(fmc_pkg::A_STATUS, 32'h0000_0001, r);
    while (s[fmc_pkg::ST_UPDATE] !== 1'b1 && k < 400)
    begin
      rdr(fmc_pkg::A_STATUS, s, r);
      k++;
    end
    `CHK(s[fmc_pkg::ST_UPDATE], 1'b1)
  endtask : wait_upd

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // Watchdog sized well above the expected run of about 5k cycles
  initial
  begin
    #400000;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    end_of_test();
  end

  // Main sequence
  initial
  begin
    cyc(3);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      rdr(ra[i], rd, rr);
      `CHK(rd, rv[i]) // reset values
    end
    rdr(8'h28, rd, rr);
    `CHK(rr, fmc_pkg::RESP_SLVERR)
    wr(8'h02, 32'h0000_0001, rr);
    `CHK(rr, fmc_pkg::RESP_SLVERR)
    wr(fmc_pkg::A_MIN_RESP, 32'h0000_0001, rr);
    rdr(fmc_pkg::A_MIN_RESP, rd, rr);
    `CHK(rd, 32'h0000_0005) // low clamp
    wr(fmc_pkg::A_MIN_RESP, 32'h0000_4e20, rr);
    rdr(fmc_pkg::A_MIN_RESP, rd, rr);
    `CHK(rd, 32'h0000_2710) // high clamp
    wr(fmc_pkg::A_MIN_RESP, 32'h0000_0005, rr);
    $display("registers test done");
    wr(fmc_pkg::A_CAL_MIN, 32'h0000_ffff, rr);
    `CHK(rr, fmc_pkg::RESP_SLVERR) // min not below full scale
    rdr(fmc_pkg::A_CAL_MIN, rd, rr);
    `CHK(rd, 32'h0000_0000) // not stored
    `CHK(irq, 1'b0)
    wr(fmc_pkg::A_MASK, 32'h0000_0008, rr);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(fmc_pkg::A_STATUS, 32'h0000_0008, rr);
    cyc(2);
    `CHK(irq, 1'b0)
    wr(fmc_pkg::A_CAL_FS, 32'h0000_8000, rr);
    `CHK(rr, fmc_pkg::RESP_OKAY) // full scale above min
    wr(fmc_pkg::A_CAL_MIN, 32'h0000_1000, rr);
    `CHK(rr, fmc_pkg::RESP_OKAY) // min below full scale
    wr(fmc_pkg::A_CAL_FS, 32'h0000_1000, rr);
    `CHK(rr, fmc_pkg::RESP_SLVERR) // full scale equal to min
    rdr(fmc_pkg::A_CAL_FS, rd, rr);
    `CHK(rd, 32'h0000_8000) // not stored
    wr(fmc_pkg::A_STATUS, 32'h0000_0008, rr);
    $display("calibration test done");
    // 2 kHz full scale at the scaled rate; a 100-cycle period reads 1 kHz, half scale
    wr(fmc_pkg::A_FS_HZ, 32'h0000_07d0, rr);
    run <= 1'b1;
    wait_upd();
    wait_upd();
    rdr(fmc_pkg::A_FREQ, rd, rr);
    `CHK(rd, 32'h000f_4240) // average frequency in mHz
    `CHK(out_value, 16'h4800) // scaled output
    `CHK(out_led, 1'b0)
    period <= 16'h0028;
    wait_upd();
    wait_upd();
    `CHK(out_value, 16'h8000) // clamp at full scale
    `CHK(out_led, 1'b1) // lamp on over-range
    rdr(fmc_pkg::A_FLAGS, rd, rr);
    `CHK(rd[1], 1'b1) // over-range flag
    period <= 16'h0064;
    wr(fmc_pkg::A_MAX_RESP, 32'h0000_012c, rr);
    wait_upd();
    wait_upd();
    rdr(fmc_pkg::A_FREQ, rd, rr);
    `CHK(rd, 32'h000f_4240) // short max response still measures
    `CHK(out_led, 1'b0) // no cut-out
    $display("measurement test done");
    // Stop the sensor with the line held high
    run <= 1'b0;
    n = 0;
    while (out_led !== 1'b1 && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    `CHK(n <= 330, 1'b1) // cut-out before the window ends
    `CHK(out_value, 16'h1000) // cut-out value
    `CHK(out_led, 1'b1) // lamp on
    `CHK(in_led, 1'b1) // input lamp held on
    rdr(fmc_pkg::A_FLAGS, rd, rr);
    `CHK(rd[0], 1'b1) // cut-out flag
    idle_lvl <= 1'b0;
    cyc(6);
    `CHK(in_led, 1'b0) // lamp follows input
    idle_lvl <= 1'b1;
    cyc(6);
    `CHK(in_led, 1'b1) // lamp follows input
    run <= 1'b1;
    cyc(400);
    `CHK(out_led, 1'b1) // no update before the minimum window
    wait_upd();
    wait_upd();
    `CHK(out_led, 1'b0) // cut-out cleared by a full window
    `CHK(out_value, 16'h4800) // measurement resumed
    $display("cut-out test done");
    end_of_test();
  end
endmodule : tb_fmc_core
